// ==== tcc_count_model.sv ====
// Free-running counter model that feeds the block
`timescale 1ns/1ps
module tcc_count_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_count_tick,
   input  wire logic        i_load,
   input  wire logic [15:0] i_load_value,
   output logic [15:0]      o_free_running_counter
);
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset)
         o_free_running_counter <= 16'h0000;
      else if (i_load)
         o_free_running_counter <= i_load_value;
      else if (i_count_tick)
         o_free_running_counter <= o_free_running_counter + 16'h0001;
   end
endmodule

// ==== tcc_pkg.sv ====
// Constants, register map and state types of the timer compare/capture control block
package tcc_pkg;
   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int          AXI_ADDR_W   = 12;
   localparam logic [7:0]  IDX_CMP1     = 8'h16;
   localparam logic [7:0]  IDX_CMP2     = 8'h18;
   localparam logic [7:0]  IDX_CMP3     = 8'h1a;
   localparam logic [7:0]  IDX_CMP4     = 8'h1c;
   localparam logic [7:0]  IDX_SHARED   = 8'h1e;
   localparam logic [7:0]  IDX_PIN_CTL  = 8'h20;
   localparam logic [7:0]  IDX_EDGE_CTL = 8'h21;
   localparam logic [7:0]  IDX_MASK1    = 8'h22;
   localparam logic [7:0]  IDX_FLAG1    = 8'h23;
   localparam logic [7:0]  IDX_MASK2    = 8'h24;
   localparam logic [7:0]  IDX_FLAG2    = 8'h25;
   localparam logic [7:0]  IDX_PULSE_ACCUM_CONTROL    = 8'h26;
   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] CMP_RESET    = 16'hffff;
   localparam logic [15:0] CNT_MAX      = 16'hffff;
   localparam logic [15:0] CNT_ZERO     = 16'h0000;
   localparam logic [7:0]  MASK2_IMPL   = 8'hf3;
   localparam logic [7:0]  FLAG2_IMPL   = 8'hf0;
   localparam logic [7:0]  MASK2_IRQ    = 8'hf0;
   localparam int          F1_SHARED    = 3;
   localparam int          F2_OVF       = 7;
   localparam int          F2_RTI       = 6;
   localparam int          F2_ACC_OVF   = 5;
   localparam int          F2_ACC_EDGE  = 4;
   localparam int          PULSE_ACCUM_CONTROL_SEL    = 2;
   localparam logic [1:0]  PIN_OFF      = 2'h0;
   localparam logic [1:0]  PIN_TOGGLE   = 2'h1;
   localparam logic [1:0]  PIN_LOW      = 2'h2;
   localparam logic [1:0]  EDGE_RISE    = 2'h1;
   localparam logic [1:0]  EDGE_FALL    = 2'h2;
   localparam logic [1:0]  EDGE_ANY     = 2'h3;
   localparam logic [1:0]  PR_DIV4      = 2'h1;
   localparam logic [1:0]  PR_DIV8      = 2'h2;
   localparam logic [1:0]  PR_DIV16     = 2'h3;
   localparam logic [4:0]  DIV1         = 5'h01;
   localparam logic [4:0]  DIV4         = 5'h04;
   localparam logic [4:0]  DIV8         = 5'h08;
   localparam logic [4:0]  DIV16        = 5'h10;
   localparam int          PRESCALE_WINDOW = 64;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      WR_IDLE  = 3'b001,
      WR_APPLY = 3'b010,
      WR_RESP  = 3'b100
   } tcc_wr_state_type;
   typedef struct packed {
      logic                  awvalid;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic                  wvalid;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  bready;
      logic                  arvalid;
      logic [AXI_ADDR_W-1:0] araddr;
      logic                  rready;
   } tcc_axi_req_type;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tcc_axi_rsp_type;
   typedef struct packed {
      logic [3:0][15:0]      cmp;
      logic [15:0]           shared;
      logic [7:0]            pin_ctl;
      logic [7:0]            edge_ctl;
      logic [7:0]            mask1;
      logic [7:0]            flag1;
      logic [7:0]            mask2;
      logic [7:0]            flag2;
      logic                  chan_sel;
      logic [1:0]            rtr;
      logic                  pr_locked;
      logic [7:0]            boot_cnt;
      logic [4:0]            presc_cnt;
      logic                  tick;
      logic [15:0]           prev_cnt;
      logic [3:0]            sync1;
      logic [3:0]            sync2;
      logic [3:0]            sync3;
      logic [3:0]            level;
      logic [3:0]            pin;
      logic [3:0]            pin_oe;
      logic [3:0]            cap_strobe;
      logic                  irq;
      tcc_wr_state_type      wr_state;
      logic [7:0]            waddr;
      logic                  waddr_ok;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  aw_have;
      logic                  w_have;
      tcc_axi_rsp_type       rsp;
   } tcc_state_type;
endpackage

// ==== tcc_timer_ctl.sv ====
// Compare/capture control, flags and register slave of the 16-bit main timer
`timescale 1ns/1ps
// Contract
// - compare values reset to all ones
// - channel select makes shared channel capture or compare
// - shared register ignores writes in capture mode
// - shared register resets to all ones
// - compare 2 to 5 match drives pin per two-bit action
// - capture edge chosen by two-bit setting
// - set flag with enabled mask requests interrupt
// - mask bits align with same flag bits
// - shared enable gates capture or compare interrupt
// - flags clear only on written one
// - counter equal compare value sets compare flag
// - shared flag set by selected function
// - selected edge sets capture flag
// - overflow enable gates overflow interrupt
// - realtime enable gates realtime interrupt
// - prescaler written once within 64 cycles
// - prescaler divides by 1, 4, 8, 16
// - upper mask2 bits enable upper flag2 bits
// - counter wrap sets overflow flag
// - realtime flag set at selected rate
// - unimplemented mask2/flag2 bits read zero
// - channel select resets zero, zero is compare
module tcc_timer_ctl
   import tcc_pkg::*;
#(
   parameter int PRESCALE_WINDOW_CYCLES = PRESCALE_WINDOW
) (
   input  wire logic            i_clk_sys,
   input  wire logic            i_reset,
   input  wire tcc_axi_req_type i_axi_req,
   output tcc_axi_rsp_type      o_axi_rsp,
   input  wire logic [15:0]     i_free_running_counter,
   input  wire logic [3:0]      i_capture_pin,
   input  wire logic            i_realtime_tick,
   input  wire logic            i_accum_overflow_event,
   input  wire logic            i_accum_edge_event,
   input  wire logic            i_special_mode,
   output logic                 o_count_tick,
   output logic [1:0]           o_prescale_select,
   output logic [1:0]           o_realtime_rate_select,
   output logic                 o_channel_select_bit,
   output logic [3:0]           o_compare_pin,
   output logic [3:0]           o_compare_pin_enable,
   output logic [3:0]           o_capture_strobe,
   output logic                 o_irq
);
   if (PRESCALE_WINDOW_CYCLES < 1 || PRESCALE_WINDOW_CYCLES > 255) begin : g_chk
      $error("PRESCALE_WINDOW_CYCLES must lie in 1..255");
   end
   localparam logic [7:0] WINDOW = 8'(PRESCALE_WINDOW_CYCLES);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
      merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic edge_hit(input logic [1:0] sel, input logic now_high);
      case (sel)
         EDGE_RISE: edge_hit = now_high;
         EDGE_FALL: edge_hit = !now_high;
         EDGE_ANY:  edge_hit = 1'b1;
         default:   edge_hit = 1'b0;
      endcase
   endfunction

   function automatic logic [4:0] presc_div(input logic [1:0] pr);
      case (pr)
         PR_DIV4:  presc_div = DIV4;
         PR_DIV8:  presc_div = DIV8;
         PR_DIV16: presc_div = DIV16;
         default:  presc_div = DIV1;
      endcase
   endfunction

   function automatic logic idx_ok(input logic [7:0] idx);
      case (idx)
         IDX_CMP1, IDX_CMP2, IDX_CMP3, IDX_CMP4, IDX_SHARED, IDX_PIN_CTL, IDX_EDGE_CTL,
         IDX_MASK1, IDX_FLAG1, IDX_MASK2, IDX_FLAG2, IDX_PULSE_ACCUM_CONTROL: idx_ok = 1'b1;
         default: idx_ok = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   localparam tcc_state_type STATE_RESET = '{
      cmp:      {4{CMP_RESET}},
      shared:   CMP_RESET,
      wr_state: WR_IDLE,
      rsp:      '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
      default:  '0
   };

   tcc_state_type st;
   tcc_state_type next_st;

   logic [3:0] edge_ev;
   logic [3:0] match;
   logic [7:0] set1;
   logic [7:0] set2;
   logic [7:0] clr1;
   logic [7:0] clr2;
   logic       step;
   logic       hit;
   logic [7:0] ridx;
   logic [1:0] act;
   logic [1:0] esel;

   always_comb begin
      next_st = st;
      edge_ev = '0;
      match = '0;
      set1 = '0;
      set2 = '0;
      clr1 = '0;
      clr2 = '0;
      hit = 1'b0;
      act = PIN_OFF;
      esel = PIN_OFF;
      ridx = i_axi_req.araddr[9:2];

      // Capture inputs: three-stage synchroniser, change accepted when stages 2 and 3 agree
      next_st.sync1 = i_capture_pin;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      next_st.cap_strobe = '0;
      for (int c = 0; c < 4; c++) begin
         esel = st.edge_ctl[7 - 2 * ((c + 1) % 4) -: 2];
         if (st.sync2[c] == st.sync3[c] && st.sync3[c] != st.level[c]) begin
            next_st.level[c] = st.sync3[c];
            edge_ev[c] = edge_hit(esel, st.sync3[c]);
         end
      end
      next_st.cap_strobe = edge_ev & {st.chan_sel, 3'b111};
      if (st.chan_sel && edge_ev[3]) begin
         next_st.shared = i_free_running_counter;
      end

      // Compares act once per counter value
      step = i_free_running_counter != st.prev_cnt;
      next_st.prev_cnt = i_free_running_counter;
      for (int k = 0; k < 4; k++) begin
         match[k] = step && i_free_running_counter == st.cmp[k];
         set1[7 - k] = match[k];
      end
      for (int c = 0; c < 3; c++) begin
         set1[2 - c] = edge_ev[c];
      end
      set1[F1_SHARED] = st.chan_sel ? edge_ev[3] :
                        (step && !st.chan_sel && i_free_running_counter == st.shared);

      // Compare pin actions for channels 2..5
      for (int k = 0; k < 4; k++) begin
         act = st.pin_ctl[7 - 2 * k -: 2];
         hit = (k < 3) ? match[k + 1] : (!st.chan_sel && set1[F1_SHARED]);
         next_st.pin_oe[k] = act != PIN_OFF && (k < 3 || !st.chan_sel);
         if (hit) begin
            case (act)
               PIN_OFF:    next_st.pin[k] = st.pin[k];
               PIN_TOGGLE: next_st.pin[k] = !st.pin[k];
               PIN_LOW:    next_st.pin[k] = 1'b0;
               default:    next_st.pin[k] = 1'b1;
            endcase
         end
      end

      set2[F2_OVF] = step && st.prev_cnt == CNT_MAX && i_free_running_counter == CNT_ZERO;
      set2[F2_RTI] = i_realtime_tick;
      set2[F2_ACC_OVF] = i_accum_overflow_event;
      set2[F2_ACC_EDGE] = i_accum_edge_event;

      // Prescaler tick for the counter
      if (st.presc_cnt >= presc_div(st.mask2[1:0]) - 5'd1) begin
         next_st.presc_cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.presc_cnt = st.presc_cnt + 5'd1;
         next_st.tick = 1'b0;
      end
      if (st.boot_cnt < WINDOW) begin
         next_st.boot_cnt = st.boot_cnt + 8'd1;
      end

      // ---------------------------------------------------------------
      // AXI4-Lite write channel
      // ---------------------------------------------------------------
      case (st.wr_state)
         WR_IDLE: begin
            if (i_axi_req.awvalid && st.rsp.awready) begin
               next_st.waddr_ok = i_axi_req.awaddr[11:10] == 2'h0 &&
                                  i_axi_req.awaddr[1:0] == 2'h0 &&
                                  idx_ok(i_axi_req.awaddr[9:2]);
               // A refused address lands on no register
               next_st.waddr = next_st.waddr_ok ? i_axi_req.awaddr[9:2] : '0;
               next_st.aw_have = 1'b1;
               next_st.rsp.awready = 1'b0;
            end
            if (i_axi_req.wvalid && st.rsp.wready) begin
               next_st.wdata = i_axi_req.wdata;
               next_st.wstrb = i_axi_req.wstrb;
               next_st.w_have = 1'b1;
               next_st.rsp.wready = 1'b0;
            end
            if (next_st.aw_have && next_st.w_have) begin
               next_st.wr_state = WR_APPLY;
            end
         end
         WR_APPLY: begin
            next_st.wr_state = WR_RESP;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = st.waddr_ok ? RESP_OKAY : RESP_SLVERR;
            case (st.waddr)
               IDX_CMP1: next_st.cmp[0] = merge16(st.cmp[0], st.wdata, st.wstrb);
               IDX_CMP2: next_st.cmp[1] = merge16(st.cmp[1], st.wdata, st.wstrb);
               IDX_CMP3: next_st.cmp[2] = merge16(st.cmp[2], st.wdata, st.wstrb);
               IDX_CMP4: next_st.cmp[3] = merge16(st.cmp[3], st.wdata, st.wstrb);
               IDX_SHARED: begin
                  if (!st.chan_sel) begin
                     next_st.shared = merge16(st.shared, st.wdata, st.wstrb);
                  end
               end
               IDX_PIN_CTL: if (st.wstrb[0]) next_st.pin_ctl = st.wdata[7:0];
               IDX_EDGE_CTL: if (st.wstrb[0]) next_st.edge_ctl = st.wdata[7:0];
               IDX_MASK1: if (st.wstrb[0]) next_st.mask1 = st.wdata[7:0];
               IDX_FLAG1: if (st.wstrb[0]) clr1 = st.wdata[7:0];
               IDX_MASK2: begin
                  if (st.wstrb[0]) begin
                     next_st.mask2[7:4] = st.wdata[7:4];
                     if (i_special_mode || (!st.pr_locked && st.boot_cnt < WINDOW)) begin
                        next_st.mask2[1:0] = st.wdata[1:0];
                        next_st.pr_locked = !i_special_mode;
                     end
                  end
               end
               IDX_FLAG2: if (st.wstrb[0]) clr2 = st.wdata[7:0] & FLAG2_IMPL;
               IDX_PULSE_ACCUM_CONTROL: begin
                  if (st.wstrb[0]) begin
                     next_st.chan_sel = st.wdata[PULSE_ACCUM_CONTROL_SEL];
                     next_st.rtr = st.wdata[1:0];
                  end
               end
               default: next_st.rsp.bresp = RESP_SLVERR;
            endcase
         end
         WR_RESP: begin
            if (i_axi_req.bready) begin
               next_st.rsp.bvalid = 1'b0;
               next_st.aw_have = 1'b0;
               next_st.w_have = 1'b0;
               next_st.rsp.awready = 1'b1;
               next_st.rsp.wready = 1'b1;
               next_st.wr_state = WR_IDLE;
            end
         end
         default: next_st.wr_state = WR_IDLE;
      endcase

      // Flags: a set in the cycle of its clear wins
      next_st.flag1 = (st.flag1 & ~clr1) | set1;
      next_st.flag2 = ((st.flag2 & ~clr2) | set2) & FLAG2_IMPL;
      next_st.irq = |(st.flag1 & st.mask1) ||
                    |(st.flag2 & st.mask2 & MASK2_IRQ);

      // ---------------------------------------------------------------
      // AXI4-Lite read channel
      // ---------------------------------------------------------------
      if (i_axi_req.arvalid && st.rsp.arready) begin
         next_st.rsp.arready = 1'b0;
         next_st.rsp.rvalid = 1'b1;
         next_st.rsp.rresp = RESP_OKAY;
         next_st.rsp.rdata = '0;
         if (i_axi_req.araddr[11:10] != 2'h0 || i_axi_req.araddr[1:0] != 2'h0) begin
            next_st.rsp.rresp = RESP_SLVERR;
         end else begin
            case (ridx)
               IDX_CMP1: next_st.rsp.rdata[15:0] = st.cmp[0];
               IDX_CMP2: next_st.rsp.rdata[15:0] = st.cmp[1];
               IDX_CMP3: next_st.rsp.rdata[15:0] = st.cmp[2];
               IDX_CMP4: next_st.rsp.rdata[15:0] = st.cmp[3];
               IDX_SHARED: next_st.rsp.rdata[15:0] = st.shared;
               IDX_PIN_CTL: next_st.rsp.rdata[7:0] = st.pin_ctl;
               IDX_EDGE_CTL: next_st.rsp.rdata[7:0] = st.edge_ctl;
               IDX_MASK1: next_st.rsp.rdata[7:0] = st.mask1;
               IDX_FLAG1: next_st.rsp.rdata[7:0] = st.flag1;
               IDX_MASK2: next_st.rsp.rdata[7:0] = st.mask2 & MASK2_IMPL;
               IDX_FLAG2: next_st.rsp.rdata[7:0] = st.flag2 & FLAG2_IMPL;
               IDX_PULSE_ACCUM_CONTROL: next_st.rsp.rdata[7:0] = {5'h00, st.chan_sel, st.rtr};
               default: next_st.rsp.rresp = RESP_SLVERR;
            endcase
         end
      end else if (st.rsp.rvalid && i_axi_req.rready) begin
         next_st.rsp.rvalid = 1'b0;
         next_st.rsp.arready = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign o_axi_rsp = st.rsp;
   assign o_count_tick = st.tick;
   assign o_prescale_select = st.mask2[1:0];
   assign o_realtime_rate_select = st.rtr;
   assign o_channel_select_bit = st.chan_sel;
   assign o_compare_pin = st.pin;
   assign o_compare_pin_enable = st.pin_oe;
   assign o_capture_strobe = st.cap_strobe;
   assign o_irq = st.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   a_shared_write_block:
   assert property (st.wr_state == WR_APPLY && st.waddr == IDX_SHARED && st.chan_sel &&
                    !edge_ev[3] |=> st.shared == $past(st.shared))
      else $error("shared register changed by write in capture mode");
   a_irq_raise:
   assert property (|(st.flag1 & st.mask1) |=> o_irq)
      else $error("enabled channel flag gave no interrupt");
   a_irq_quiet:
   assert property (!(|(st.flag1 & st.mask1)) && !(|(st.flag2 & st.mask2 & MASK2_IRQ))
                    |=> !o_irq)
      else $error("interrupt without enabled flag");
   a_overflow_flag:
   assert property (st.prev_cnt == CNT_MAX && i_free_running_counter == CNT_ZERO
                    |=> st.flag2[F2_OVF])
      else $error("counter wrap did not set overflow flag");
   a_compare_flag:
   assert property (match[0] |=> st.flag1[7])
      else $error("compare match did not set flag");
   a_prescale_lock:
   assert property (st.boot_cnt == WINDOW && !i_special_mode |=> $stable(st.mask2[1:0]))
      else $error("prescaler changed after window");
   a_prescale_div16:
   assert property (o_count_tick && o_prescale_select == PR_DIV16 && $stable(o_prescale_select)
                    |=> !o_count_tick [*8])
      else $error("divide by 16 ticks too early");
   a_flag_keep:
   assert property (st.flag1[7] && !(st.wr_state == WR_APPLY && st.waddr == IDX_FLAG1 &&
                    st.wstrb[0] && st.wdata[7]) |=> st.flag1[7])
      else $error("flag lost without written one");
   a_read_answer:
   assert property (i_axi_req.arvalid && o_axi_rsp.arready |=> o_axi_rsp.rvalid)
      else $error("read not answered next cycle");
   a_capture_latch:
   assert property (st.chan_sel && edge_ev[3] |=> st.shared == $past(i_free_running_counter))
      else $error("capture did not latch counter");
   a_strobe_select:
   assert property (o_capture_strobe[3] |-> $past(st.chan_sel))
      else $error("shared capture strobe outside capture mode");
   a_pin_clear:
   assert property (match[1] && st.pin_ctl[7 -: 2] == PIN_LOW |=> !o_compare_pin[0])
      else $error("clear action left compare pin high");
   a_shared_compare:
   assert property (step && !st.chan_sel && i_free_running_counter == st.shared
                    |=> st.flag1[F1_SHARED])
      else $error("compare five match did not set shared flag");

   c_shared_capture: cover property (st.chan_sel && edge_ev[3]);
   c_prescale_set: cover property (st.wr_state == WR_APPLY && st.waddr == IDX_MASK2 &&
                                   !st.pr_locked);
   c_irq_rise: cover property (!o_irq ##1 o_irq);
   c_pin_toggle: cover property (hit && act == PIN_TOGGLE);
endmodule

// ==== test_timer_compare_capture_ctl.sv ====
// Self-checking bench of the timer compare/capture control block
`timescale 1ns/1ps
module test_timer_compare_capture_ctl;
   import tcc_pkg::*;
   logic            i_clk_sys = 1'b0;
   logic            i_reset   = 1'b1;
   tcc_axi_req_type req       = '0;
   tcc_axi_rsp_type rsp;
   logic [15:0]     cnt;
   logic [15:0]     ld_val    = 16'h0000;
   logic            ld        = 1'b0;
   logic [3:0]      cap       = 4'h0;
   logic            rti       = 1'b0;
   logic            tick;
   logic [1:0]      psel;
   logic [1:0]      rsel;
   logic            csel;
   logic [3:0]      pin;
   logic [3:0]      pin_en;
   logic [3:0]      strobe;
   logic            irq;
   logic [31:0]     rd;
   logic [1:0]      rs;
   int              err_total = 0;
   int              n_checks  = 0;
   initial forever #2.5 i_clk_sys = ~i_clk_sys;
   tcc_timer_ctl #(.PRESCALE_WINDOW_CYCLES(8)) tcc_timer_ctl_inst (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_axi_req(req), .o_axi_rsp(rsp),
      .i_free_running_counter(cnt), .i_capture_pin(cap), .i_realtime_tick(rti),
      .i_accum_overflow_event(1'b0), .i_accum_edge_event(1'b0), .i_special_mode(1'b0),
      .o_count_tick(tick), .o_prescale_select(psel), .o_realtime_rate_select(rsel),
      .o_channel_select_bit(csel), .o_compare_pin(pin), .o_compare_pin_enable(pin_en),
      .o_capture_strobe(strobe), .o_irq(irq));
   tcc_count_model tcc_count_model_inst (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_count_tick(tick), .i_load(ld),
      .i_load_value(ld_val), .o_free_running_counter(cnt));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         err_total++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic tmo(input int n);
      if (n >= 200) begin
         $display("[ERR] bus wait expected answer seen none");
         err_total++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      req.awaddr  <= {2'b00, idx, 2'b00};
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         n++;
         if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1 && n < 200);
      rs = rsp.bresp;
      req.bready <= 1'b0;
      tmo(n);
   endtask
   task automatic rdr(input logic [7:0] idx);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      req.araddr  <= {2'b00, idx, 2'b00};
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         n++;
         if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1 && n < 200);
      rd = rsp.rdata;
      rs = rsp.rresp;
      req.rready <= 1'b0;
      tmo(n);
   endtask
   task automatic load(input logic [15:0] v);
      @(posedge i_clk_sys);
      ld     <= 1'b1;
      ld_val <= v;
      @(posedge i_clk_sys);
      ld     <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 5; i++) begin
         rdr(8'(IDX_CMP1 + 2 * i));
         chk("cmp_reset", 32'hffff, rd);
      end
      for (int i = 0; i < 7; i++) begin
         rdr(8'(IDX_PIN_CTL + i));
         chk("ctl_reset", 32'h0, rd);
      end
      chk("chan_sel", 32'h0, {31'h0, csel});
      $display("test reset done");
   endtask
   task automatic t_compare();
      wr(IDX_MASK1, 32'h40);
      wr(IDX_CMP2, 32'h0120);
      for (int c = 1; c < 4; c++) begin
         wr(IDX_PIN_CTL, 32'(c << 6));
         load(16'h0110);
         cyc(24);
         chk("pin2", {31'h0, c[0]}, {31'h0, pin[0]});
      end
      chk("pin2_en", 32'h1, {31'h0, pin_en[0]});
      rdr(IDX_FLAG1);
      chk("flag1", 32'h40, rd);
      chk("irq", 32'h1, {31'h0, irq});
      wr(IDX_FLAG1, 32'hbf);
      rdr(IDX_FLAG1);
      chk("flag1_kept", 32'h40, rd);
      wr(IDX_FLAG1, 32'h40);
      rdr(IDX_FLAG1);
      chk("flag1_clr", 32'h0, rd);
      chk("irq_clr", 32'h0, {31'h0, irq});
      $display("test compare done");
   endtask
   task automatic t_shared();
      int n;
      n = 0;
      wr(IDX_PULSE_ACCUM_CONTROL, 32'h06);
      chk("chan_sel", 32'h1, {31'h0, csel});
      chk("rate_sel", 32'h2, {30'h0, rsel});
      wr(IDX_SHARED, 32'h1234);
      rdr(IDX_SHARED);
      chk("shared_cap", 32'hffff, rd);
      wr(IDX_EDGE_CTL, 32'h60);
      wr(IDX_MASK1, 32'h08);
      @(posedge i_clk_sys);
      cap <= 4'h9;
      repeat (8) begin
         @(posedge i_clk_sys);
         if (strobe === 4'h8) n++;
      end
      chk("strobe4", 32'h1, 32'(n));
      rdr(IDX_FLAG1);
      chk("flag1_cap", 32'h08, rd);
      chk("irq_cap", 32'h1, {31'h0, irq});
      wr(IDX_FLAG1, 32'h08);
      cap <= 4'h8;
      cyc(8);
      rdr(IDX_FLAG1);
      chk("flag1_fall", 32'h04, rd);
      wr(IDX_FLAG1, 32'h04);
      wr(IDX_PULSE_ACCUM_CONTROL, 32'h00);
      wr(IDX_SHARED, 32'h1234);
      rdr(IDX_SHARED);
      chk("shared_cmp", 32'h1234, rd);
      $display("test shared done");
   endtask
   task automatic t_ovf();
      wr(IDX_MASK1, 32'h00);
      wr(IDX_MASK2, 32'h8c);
      rdr(IDX_MASK2);
      chk("mask2_rd", 32'h80, rd);
      load(16'hfff0);
      cyc(30);
      @(posedge i_clk_sys);
      rti <= 1'b1;
      @(posedge i_clk_sys);
      rti <= 1'b0;
      cyc(2);
      rdr(IDX_FLAG2);
      chk("flag2", 32'hc0, rd);
      chk("irq_ovf", 32'h1, {31'h0, irq});
      wr(IDX_FLAG2, 32'h80);
      cyc(2);
      chk("irq_rti_off", 32'h0, {31'h0, irq});
      rdr(8'h30);
      chk("unmapped", 32'h2, {30'h0, rs});
      $display("test overflow done");
   endtask
   task automatic t_presc();
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_reset <= 1'b1;
      cyc(2);
      i_reset <= 1'b0;
      wr(IDX_MASK2, 32'h03);
      cyc(20);
      wr(IDX_MASK2, 32'h01);
      rdr(IDX_MASK2);
      chk("mask2_pr", 32'h03, rd);
      chk("psel", 32'h3, {30'h0, psel});
      repeat (64) begin
         @(posedge i_clk_sys);
         if (tick === 1'b1) n++;
      end
      chk("ticks", 32'h4, 32'(n));
      $display("test prescale done");
   endtask
   initial begin
      cyc(16);
      i_reset <= 1'b0;
      t_reset();
      t_compare();
      t_shared();
      t_ovf();
      t_presc();
      final_report();
   end
endmodule
